// File: common/oh_map.svh
// Purpose: Register offsets, control bit positions, reset values and overhead byte values.
// Assumes: Included by its bare name from the transmit overhead design.
// Notes: Definitions only.
`ifndef OH_MAP_SVH
`define OH_MAP_SVH

// ==========================================================================
// Register offsets
`define REG_STATUS 12'h000
`define REG_SOAK 12'h004
`define REG_CTRL 12'h008
`define REG_RAM_ADDR 12'h00C
`define REG_RAM_DATA 12'h010

// ==========================================================================
// Control register bit positions
`define CTRL_FORCE_LINE_RF 0
`define CTRL_FORCE_PATH_RF 1
`define CTRL_FORCE_PATH_RD 2
`define CTRL_SDH 3
`define CTRL_PROGRAM 4
`define CTRL_SOAK_EN 5
`define CTRL_SEND_LINE_AIS 6
`define CTRL_SEND_PATH_AIS 7

// ==========================================================================
// Reset values
`define CTRL_RESET 8'h00
`define SOAK_RESET 16'h0100

// ==========================================================================
// Overhead byte values
`define OH_A1 8'hF6
`define OH_A2 8'h28
`define OH_ORDERWIRE 8'h7F
`define OH_H1_FIRST_SONET 8'h62
`define OH_H1_FIRST_SDH 8'h6A
`define OH_H1_LATER_SONET 8'h93
`define OH_H1_LATER_SDH 8'h9B
`define OH_H2_FIRST 8'h0A
`define OH_ONES 8'hFF
`define OH_ZERO 8'h00
`define OH_C2 8'h13
`define LINE_RF_BITS 3'h6
`define PATH_RF_CODE 4'h9
`define B3_COUNT_MAX 4'h8
`define B2_COUNT_MAX 7'h60
`define PRD_NONE 2'h0
`define PRD_LABEL 2'h1
`define PRD_AIS_LOP 2'h2
`define PRD_PATH_UNEQUIPPED 2'h3

`endif

// File: common/sonet_oh_pkg.sv
// Purpose: Types shared by the transmit overhead design.
// Assumes: Nothing is imported; users write the package name.
// Notes: Overhead kinds classify every overhead RAM location.
package sonet_oh_pkg;

	// ==========================================================================
	// Overhead RAM walker states
	typedef enum logic [2:0] {
		ST_INIT = 3'b001,
		ST_IDLE = 3'b010,
		ST_WALK = 3'b100
	} walk_state_t;

	// ==========================================================================
	// Kinds of overhead location
	typedef enum logic [4:0] {
		K_ZERO, K_A1, K_A2, K_C1, K_B1, K_ORDERWIRE, K_H1_FIRST, K_H1, K_H2_FIRST, K_H2, K_H3,
		K_B2, K_K2_FIRST, K_Z2_THIRD, K_J1, K_B3, K_C2, K_G1, K_TRACE
	} oh_kind_t;

endpackage

// File: verilog/byte_fifo.sv
// Purpose: Small payload FIFO with valid and ready on both sides.
// Assumes: One clock; depth is a power of two.
// Notes: The input ready comes straight from a flip-flop.
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("FIFO depth must be a power of two of at least two.");
		end
	endgenerate

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic in_ready;
	} fifo_state_t;

	fifo_state_t q;
	fifo_state_t s;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	// ==========================================================================
	// Next state
	assign push = in_valid & q.in_ready;
	assign pop = out_ready & out_valid;
	assign out_valid = (q.cnt != '0);
	assign out_data = mem[q.rp];
	assign in_ready = q.in_ready;

	always_comb begin
		s = q;
		if (push) begin
			s.wp = q.wp + 1'b1;
		end
		if (pop) begin
			s.rp = q.rp + 1'b1;
		end
		s.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		s.in_ready = (s.cnt < (AW + 1)'(DEPTH));
	end

	// ==========================================================================
	// Registers and storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '{wp: '0, rp: '0, cnt: '0, in_ready: 1'b1};
		end else begin
			q <= s;
		end
	end

	always_ff @(posedge pclk) begin
		if (push) begin
			mem[q.wp] <= in_data;
		end
	end

endmodule // byte_fifo

// File: verilog/sonet_tx_overhead_insert.sv
// Function
// R1 - C1 bytes 11 and 12 start as sequence in SONET, zero in SDH, never rewritten.
// R2 - Pointer bytes carry fixed first and later H1, H2 values and zero H3.
// R3 - Line or path AIS sends all ones in place of bytes, RAM untouched.
// R4 - When AIS ends the stored RAM values are sent again.
// R5 - Line remote failure sends 110 in first K2 bits 6-8, stream only.
// R6 - Line remote failure follows receive frame loss, signal loss or line AIS.
// R7 - Path remote failure code 1001 in G1 on those or pointer loss, path AIS.
// R8 - Otherwise G1 bits 1-4 carry received B3 errors, zero to eight, each frame.
// R9 - Third Z2 bits 2-8 carry received B2 errors, up to 0x60, each frame.
// R10 - G1 bits 5-6 encode remote defect: label, AIS or pointer or soak, unequipped.
// R11 - Enabled soak counter raises the defect after lasting cell alignment loss.
// R12 - Control bits force line failure, path failure and path defect; control at 008.
// R13 - B1 is even BIP-8 over the previous scrambled frame.
// R14 - B2 per STS is even parity over line overhead and envelope before scrambling.
// R15 - Line overhead is transport rows from first H1 row to the frame end.
// R16 - B3 is even BIP-8 over the previous envelope before scrambling.
// R17 - The 64 byte trace is software written, default zero, never rewritten.
// R18 - Reset or framing mode change sets bytes without defaults to zero.
// R19 - Program mode suspends the per-frame overwrites until it ends.
//
// Purpose: Transmit overhead RAM, parity bytes, alarm substitution and remote indications.
// Assumes: Receive defect flags and counts and the scrambled return come from logic on pclk.
// Notes: The envelope is frame aligned, one path overhead column right after the transport overhead.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "oh_map.svh"
module sonet_tx_overhead_insert #(
	parameter int STS_N = 12,
	parameter int FIFO_DEPTH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic overhead_program_mode_pin,
	input wire logic sdh_mode_pin,
	input wire logic rx_frame_loss,
	input wire logic rx_signal_loss,
	input wire logic rx_line_alarm_signal,
	input wire logic rx_pointer_loss,
	input wire logic rx_path_alarm_signal,
	input wire logic rx_payload_label_mismatch,
	input wire logic rx_path_unequipped,
	input wire logic rx_cell_alignment_loss,
	input wire logic [3:0] rx_b3_errors,
	input wire logic [6:0] rx_b2_errors,
	input wire logic [7:0] cell_data,
	input wire logic cell_valid,
	output logic cell_ready,
	output logic [7:0] tx_data,
	output logic tx_sof,
	input wire logic [7:0] scr_data,
	input wire logic scr_sof
);
	localparam int TOH = 27 * STS_N;
	localparam int TRACE_BASE = TOH + 9;
	localparam int DEPTH = TRACE_BASE + 64;
	localparam int AW = $clog2(DEPTH);
	localparam int ROW_LEN = 90 * STS_N;
	localparam int CW = $clog2(ROW_LEN);
	localparam bit RATE622 = (STS_N == 12);

	generate
		if (STS_N != 3 && STS_N != 12) begin : g_bad_rate
			$error("STS_N must be 3 or 12.");
		end
	endgenerate

	typedef struct packed {
		sonet_oh_pkg::walk_state_t st;
		logic [AW-1:0] walk;
		logic [3:0] row;
		logic [CW-1:0] col;
		logic [7:0] tx_data;
		logic tx_sof;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [7:0] ctrl;
		logic [15:0] soak_lim;
		logic [15:0] soak_cnt;
		logic [AW-1:0] ram_addr;
		logic [1:0] pgm_sync;
		logic [1:0] sdh_sync;
		logic sdh_q;
		logic [7:0] b1_acc;
		logic [7:0] b1;
		logic [STS_N-1:0][7:0] b2_acc;
		logic [STS_N-1:0][7:0] b2;
		logic [7:0] b3_acc;
		logic [7:0] b3;
		logic [5:0] j1_ptr;
	} tx_state_t;

	tx_state_t q;
	tx_state_t s;
	logic [7:0] ram [DEPTH];
	logic ram_we;
	logic [AW-1:0] ram_wa;
	logic [7:0] ram_wd;
	logic walk_we;
	logic fifo_pop;
	logic fifo_valid;
	logic [7:0] fifo_data;
	logic pgm;
	logic sdh;
	logic line_ais;
	logic path_ais;
	logic line_rf;
	logic path_rf;
	logic soak_hit;
	logic [1:0] prd;
	logic [3:0] b3_cnt;
	logic [6:0] b2_cnt;
	logic cur_toh;
	logic cur_poh;
	logic [AW-1:0] cur_idx;
	sonet_oh_pkg::oh_kind_t cur_kind;
	sonet_oh_pkg::oh_kind_t walk_kind;
	logic [7:0] cur_byte;

	// ==========================================================================
	// Location decoding
	function automatic sonet_oh_pkg::oh_kind_t kind_of(input logic [AW-1:0] idx);
		int i;
		int sts;
		i = int'(idx);
		sts = i % STS_N;
		kind_of = sonet_oh_pkg::K_ZERO;
		if (i >= TRACE_BASE) begin
			kind_of = sonet_oh_pkg::K_TRACE;
		end else if (i >= TOH) begin
			case (i - TOH)
				0: kind_of = sonet_oh_pkg::K_J1;
				1: kind_of = sonet_oh_pkg::K_B3;
				2: kind_of = sonet_oh_pkg::K_C2;
				3: kind_of = sonet_oh_pkg::K_G1;
				default: kind_of = sonet_oh_pkg::K_ZERO;
			endcase
		end else begin
			case ((i / (3 * STS_N)) * 3 + (i % (3 * STS_N)) / STS_N)
				0: kind_of = sonet_oh_pkg::K_A1;
				1: kind_of = sonet_oh_pkg::K_A2;
				2: kind_of = sonet_oh_pkg::K_C1;
				3: kind_of = (sts == 0) ? sonet_oh_pkg::K_B1 : sonet_oh_pkg::K_ZERO;
				4, 6, 7, 8, 15, 16, 17, 18, 19, 20, 21, 22, 23, 26: begin
					kind_of = (sts == 0) ? sonet_oh_pkg::K_ORDERWIRE : sonet_oh_pkg::K_ZERO;
				end
				9: kind_of = (sts == 0) ? sonet_oh_pkg::K_H1_FIRST : sonet_oh_pkg::K_H1;
				10: kind_of = (sts == 0) ? sonet_oh_pkg::K_H2_FIRST : sonet_oh_pkg::K_H2;
				11: kind_of = sonet_oh_pkg::K_H3;
				12: kind_of = sonet_oh_pkg::K_B2;
				14: kind_of = (sts == 0) ? sonet_oh_pkg::K_K2_FIRST : sonet_oh_pkg::K_ZERO;
				25: kind_of = (sts == 2) ? sonet_oh_pkg::K_Z2_THIRD : sonet_oh_pkg::K_ZERO;
				default: kind_of = sonet_oh_pkg::K_ZERO;
			endcase
		end
	endfunction

	// Value written at reset or framing mode change.
	function automatic logic [7:0] default_of(input logic [AW-1:0] idx, input logic sdh_mode);
		logic [7:0] sts;
		sts = 8'(int'(idx) % STS_N);
		case (kind_of(idx))
			sonet_oh_pkg::K_A1: default_of = `OH_A1;
			sonet_oh_pkg::K_A2: default_of = `OH_A2;
			sonet_oh_pkg::K_C1: begin
				if (!sdh_mode || sts == 8'h00 || (RATE622 && sts < 8'h03)) begin
					default_of = sts + 8'h01; // see R1
				end else begin
					default_of = `OH_ZERO; // see R1
				end
			end
			sonet_oh_pkg::K_ORDERWIRE: default_of = `OH_ORDERWIRE;
			sonet_oh_pkg::K_H1_FIRST: default_of = sdh_mode ? `OH_H1_FIRST_SDH : `OH_H1_FIRST_SONET; // see R2
			sonet_oh_pkg::K_H1: default_of = sdh_mode ? `OH_H1_LATER_SDH : `OH_H1_LATER_SONET; // see R2
			sonet_oh_pkg::K_H2_FIRST: default_of = `OH_H2_FIRST; // see R2
			sonet_oh_pkg::K_H2: default_of = `OH_ONES; // see R2
			sonet_oh_pkg::K_C2: default_of = `OH_C2;
			default: default_of = `OH_ZERO; // see R18
		endcase
	endfunction

	// ==========================================================================
	// Conditions
	assign pgm = q.pgm_sync[1] | q.ctrl[`CTRL_PROGRAM];
	assign sdh = q.sdh_sync[1] | q.ctrl[`CTRL_SDH];
	assign line_ais = q.ctrl[`CTRL_SEND_LINE_AIS];
	assign path_ais = q.ctrl[`CTRL_SEND_PATH_AIS];
	assign line_rf = q.ctrl[`CTRL_FORCE_LINE_RF] | rx_frame_loss | rx_signal_loss | rx_line_alarm_signal; // see R6, R12
	assign path_rf = q.ctrl[`CTRL_FORCE_PATH_RF] | rx_frame_loss | rx_signal_loss | rx_line_alarm_signal
		| rx_pointer_loss | rx_path_alarm_signal; // see R7, R12
	assign soak_hit = q.ctrl[`CTRL_SOAK_EN] && (q.soak_cnt > q.soak_lim); // see R11
	assign prd = rx_path_unequipped ? `PRD_PATH_UNEQUIPPED
		: (q.ctrl[`CTRL_FORCE_PATH_RD] | rx_path_alarm_signal | rx_pointer_loss | soak_hit) ? `PRD_AIS_LOP
		: rx_payload_label_mismatch ? `PRD_LABEL : `PRD_NONE; // see R10, R12
	assign b3_cnt = (rx_b3_errors > `B3_COUNT_MAX) ? `B3_COUNT_MAX : rx_b3_errors; // see R8
	assign b2_cnt = (rx_b2_errors > `B2_COUNT_MAX) ? `B2_COUNT_MAX : rx_b2_errors; // see R9
	assign cur_toh = (q.col < CW'(3 * STS_N));
	assign cur_poh = (q.col == CW'(3 * STS_N));
	assign cur_idx = cur_toh ? AW'(int'(q.row) * 3 * STS_N + int'(q.col))
		: (q.row == 4'h0) ? AW'(TRACE_BASE + int'(q.j1_ptr)) : AW'(TOH + int'(q.row));
	assign cur_kind = kind_of(cur_idx);
	assign walk_kind = kind_of(q.walk);

	// ==========================================================================
	// Outgoing byte
	always_comb begin
		cur_byte = (q.st == sonet_oh_pkg::ST_INIT) ? default_of(cur_idx, sdh) : ram[cur_idx]; // see R18
		fifo_pop = 1'b0;
		if (cur_toh) begin
			if (line_ais && q.row >= 4'h3) begin
				cur_byte = `OH_ONES; // see R3
			end else if (path_ais && (cur_kind == sonet_oh_pkg::K_H1_FIRST || cur_kind == sonet_oh_pkg::K_H1
				|| cur_kind == sonet_oh_pkg::K_H2_FIRST || cur_kind == sonet_oh_pkg::K_H2
				|| cur_kind == sonet_oh_pkg::K_H3)) begin
				cur_byte = `OH_ONES; // see R3
			end else if (cur_kind == sonet_oh_pkg::K_K2_FIRST && line_rf) begin
				cur_byte = {cur_byte[7:3], `LINE_RF_BITS}; // see R5
			end
		end else if (line_ais || path_ais) begin
			cur_byte = `OH_ONES; // see R3
		end else if (!cur_poh) begin
			cur_byte = fifo_valid ? fifo_data : `OH_ZERO;
			fifo_pop = 1'b1;
		end
	end

	// ==========================================================================
	// Next state
	always_comb begin
		s = q;
		ram_we = 1'b0;
		ram_wa = q.walk;
		ram_wd = default_of(q.walk, sdh);
		walk_we = 1'b0;
		s.pgm_sync = {q.pgm_sync[0], overhead_program_mode_pin};
		s.sdh_sync = {q.sdh_sync[0], sdh_mode_pin};
		s.sdh_q = sdh;
		s.pready = psel & ~penable;
		s.pslverr = psel & ~penable & ~(paddr == `REG_STATUS || paddr == `REG_SOAK
			|| paddr == `REG_CTRL || paddr == `REG_RAM_ADDR || paddr == `REG_RAM_DATA);
		if (psel && !penable && !pwrite) begin
			case (paddr)
				`REG_STATUS: s.prdata = {24'h0000_00, soak_hit, q.st == sonet_oh_pkg::ST_INIT, sdh, pgm,
					prd, path_rf, line_rf};
				`REG_SOAK: s.prdata = {16'h0000, q.soak_lim};
				`REG_CTRL: s.prdata = {24'h0000_00, q.ctrl};
				`REG_RAM_ADDR: s.prdata = {{(32 - AW){1'b0}}, q.ram_addr};
				`REG_RAM_DATA: s.prdata = {24'h0000_00, (int'(q.ram_addr) < DEPTH) ? ram[q.ram_addr] : 8'h00};
				default: s.prdata = 32'h0000_0000;
			endcase
		end
		if (psel && penable && q.pready && pwrite && !q.pslverr) begin
			case (paddr)
				`REG_SOAK: s.soak_lim = pwdata[15:0];
				`REG_CTRL: s.ctrl = pwdata[7:0]; // see R12
				`REG_RAM_ADDR: s.ram_addr = pwdata[AW-1:0];
				`REG_RAM_DATA: begin
					s.ram_addr = q.ram_addr + 1'b1;
					if (int'(q.ram_addr) < DEPTH && q.st != sonet_oh_pkg::ST_INIT) begin
						ram_we = 1'b1; // see R17
						ram_wa = q.ram_addr;
						ram_wd = pwdata[7:0];
					end
				end
				default: s.ctrl = q.ctrl;
			endcase
		end
		if (sdh != q.sdh_q) begin
			s.st = sonet_oh_pkg::ST_INIT; // see R18
			s.walk = '0;
		end else begin
			unique case (q.st)
				sonet_oh_pkg::ST_INIT: begin
					ram_we = 1'b1; // see R18
					ram_wa = q.walk;
					ram_wd = default_of(q.walk, sdh);
					s.walk = q.walk + 1'b1;
					if (int'(q.walk) == DEPTH - 1) begin
						s.st = sonet_oh_pkg::ST_IDLE;
					end
				end
				sonet_oh_pkg::ST_IDLE: begin
					if (!pgm && q.row == 4'h0 && cur_poh) begin
						s.st = sonet_oh_pkg::ST_WALK;
						s.walk = '0;
					end
				end
				sonet_oh_pkg::ST_WALK: begin
					if (pgm) begin
						s.st = sonet_oh_pkg::ST_IDLE; // see R19
					end else if (!ram_we) begin
						s.walk = q.walk + 1'b1;
						if (int'(q.walk) == TRACE_BASE - 1) begin
							s.st = sonet_oh_pkg::ST_IDLE;
						end
						ram_wa = q.walk;
						walk_we = 1'b1;
						case (walk_kind)
							sonet_oh_pkg::K_A1: ram_wd = `OH_A1;
							sonet_oh_pkg::K_A2: ram_wd = `OH_A2;
							sonet_oh_pkg::K_B1: ram_wd = q.b1; // see R13
							sonet_oh_pkg::K_H1_FIRST: ram_wd = sdh ? `OH_H1_FIRST_SDH : `OH_H1_FIRST_SONET; // see R2
							sonet_oh_pkg::K_H2_FIRST: ram_wd = `OH_H2_FIRST; // see R2
							sonet_oh_pkg::K_B2: ram_wd = q.b2[int'(q.walk) % STS_N]; // see R14
							sonet_oh_pkg::K_Z2_THIRD: ram_wd = {ram[q.walk][7], b2_cnt}; // see R9
							sonet_oh_pkg::K_B3: ram_wd = q.b3; // see R16
							sonet_oh_pkg::K_C2: ram_wd = `OH_C2;
							sonet_oh_pkg::K_G1: ram_wd = {path_rf ? `PATH_RF_CODE : b3_cnt, prd, 2'b00}; // see R7, R8, R10
							default: walk_we = 1'b0; // see R1, R17
						endcase
						ram_we = walk_we;
					end
				end
			endcase
		end
		if (q.ctrl[`CTRL_SOAK_EN] && rx_cell_alignment_loss) begin
			s.soak_cnt = (q.soak_cnt == 16'hFFFF) ? q.soak_cnt : q.soak_cnt + 16'h0001; // see R11
		end else begin
			s.soak_cnt = 16'h0000;
		end
		s.col = (q.col == CW'(ROW_LEN - 1)) ? '0 : q.col + 1'b1;
		if (q.col == CW'(ROW_LEN - 1)) begin
			s.row = (q.row == 4'h8) ? 4'h0 : q.row + 4'h1;
		end
		s.tx_data = cur_byte;
		s.tx_sof = (q.row == 4'h0 && q.col == '0);
		if (s.tx_sof) begin
			s.b2 = q.b2_acc; // see R14
			s.b2_acc = '0;
			s.b3 = q.b3_acc; // see R16
			s.b3_acc = 8'h00;
			s.j1_ptr = q.j1_ptr + 6'h01;
		end
		if (!cur_toh || q.row >= 4'h3) begin
			s.b2_acc[int'(q.col) % STS_N] = s.b2_acc[int'(q.col) % STS_N] ^ cur_byte; // see R14, R15
		end
		if (!cur_toh) begin
			s.b3_acc = s.b3_acc ^ cur_byte; // see R16
		end
		if (scr_sof) begin
			s.b1 = q.b1_acc; // see R13
			s.b1_acc = scr_data;
		end else begin
			s.b1_acc = q.b1_acc ^ scr_data; // see R13
		end
	end

	// ==========================================================================
	// Registers, overhead RAM and payload FIFO
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.st <= sonet_oh_pkg::ST_INIT;
			q.ctrl <= `CTRL_RESET;
			q.soak_lim <= `SOAK_RESET;
		end else begin
			q <= s;
		end
	end

	always_ff @(posedge pclk) begin
		if (ram_we) begin
			ram[ram_wa] <= ram_wd;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign tx_data = q.tx_data;
	assign tx_sof = q.tx_sof;

	byte_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_payload_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_data(cell_data),
		.in_valid(cell_valid),
		.in_ready(cell_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	// ==========================================================================
	// Assertions
	line_ais_ones_a: assert property (@(posedge pclk) disable iff (!presetn) // see R3
		(line_ais && q.row >= 4'h3) |=> (tx_data == `OH_ONES)) else $error("Line AIS byte not all ones.");
	path_ais_ptr_a: assert property (@(posedge pclk) disable iff (!presetn) // see R3
		(path_ais && cur_toh && cur_kind == sonet_oh_pkg::K_H3) |=> (tx_data == `OH_ONES))
		else $error("Path AIS pointer not all ones.");
	ram_returns_a: assert property (@(posedge pclk) disable iff (!presetn) // see R4
		(!line_ais && !path_ais && (cur_toh || cur_poh) && cur_kind != sonet_oh_pkg::K_K2_FIRST
		&& q.st != sonet_oh_pkg::ST_INIT)
		|=> (tx_data == $past(ram[cur_idx]))) else $error("Stored overhead not sent.");
	k2_failure_a: assert property (@(posedge pclk) disable iff (!presetn) // see R5
		(line_rf && !line_ais && cur_toh && cur_kind == sonet_oh_pkg::K_K2_FIRST)
		|=> (tx_data[2:0] == 3'b110)) else $error("K2 remote failure bits wrong.");
	g1_failure_a: assert property (@(posedge pclk) disable iff (!presetn) // see R7
		(walk_we && walk_kind == sonet_oh_pkg::K_G1 && rx_pointer_loss) |-> (ram_wd[7:4] == 4'h9))
		else $error("G1 path failure code missing.");
	g1_count_a: assert property (@(posedge pclk) disable iff (!presetn) // see R8
		(walk_we && walk_kind == sonet_oh_pkg::K_G1 && !path_rf) |-> (ram_wd[7:4] <= 4'h8))
		else $error("G1 error count out of range.");
	z2_count_a: assert property (@(posedge pclk) disable iff (!presetn) // see R9
		(walk_we && walk_kind == sonet_oh_pkg::K_Z2_THIRD) |-> (ram_wd[6:0] <= 7'h60))
		else $error("Z2 error count out of range.");
	prd_unequipped_a: assert property (@(posedge pclk) disable iff (!presetn) // see R10
		(walk_we && walk_kind == sonet_oh_pkg::K_G1 && rx_path_unequipped) |-> (ram_wd[3:2] == 2'b11))
		else $error("Unequipped defect code wrong.");
	soak_defect_a: assert property (@(posedge pclk) disable iff (!presetn) // see R11
		(walk_we && walk_kind == sonet_oh_pkg::K_G1 && q.ctrl[`CTRL_SOAK_EN] && q.soak_cnt > q.soak_lim
		&& !rx_path_unequipped) |-> (ram_wd[3:2] == 2'b10))
		else $error("Soak defect not signalled.");
	program_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // see R19
		(pgm && q.st != sonet_oh_pkg::ST_INIT) |-> (!ram_we || (psel && penable && pwrite && paddr == `REG_RAM_DATA)))
		else $error("Overwrite during program mode.");
	init_sweep_a: assert property (@(posedge pclk) disable iff (!presetn) // see R18
		(q.st == sonet_oh_pkg::ST_INIT && sdh == q.sdh_q) |-> (ram_we && ram_wa == q.walk))
		else $error("Initial sweep skipped a location.");

endmodule // sonet_tx_overhead_insert

// File: verif/remote_line_rx.sv
// Purpose: Far-end receiver model; echoes the stream as scrambled return and keeps the last frame.
// Assumes: tx_sof marks byte 0 of a frame of 9 rows by 90*STS_N bytes.
// Notes: The echo stands in for the scrambler; parity of frame and envelope is gathered.
`timescale 1ns/1ps
module remote_line_rx #(
	parameter int STS_N = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] tx_data,
	input wire logic tx_sof,
	output logic [7:0] scr_data,
	output logic scr_sof
);
	// ==========
	// Frame capture
	localparam int COLS = 90 * STS_N;
	logic [7:0] fb [9*COLS];
	logic [7:0] acc_all, acc_spe, last_all, last_spe;
	logic [7:0] acc_b2 [STS_N];
	logic [7:0] last_b2 [STS_N];
	int pos, p;
	assign scr_data = tx_data;
	assign scr_sof = tx_sof;
	assign p = tx_sof ? 0 : pos + 1;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos <= 0;
			acc_all <= 8'h00;
			acc_spe <= 8'h00;
		end else begin
			if (p < 9 * COLS) fb[p] <= tx_data;
			pos <= p;
			acc_all <= (tx_sof ? 8'h00 : acc_all) ^ tx_data;
			acc_spe <= (tx_sof ? 8'h00 : acc_spe) ^ ((p % COLS >= 3 * STS_N) ? tx_data : 8'h00);
			if (tx_sof) begin
				last_all <= acc_all;
				last_spe <= acc_spe;
			end
			for (int k = 0; k < STS_N; k++) begin
				acc_b2[k] <= (tx_sof ? 8'h00 : acc_b2[k])
					^ ((p % STS_N == k && (p >= 3 * COLS || p % COLS >= 3 * STS_N)) ? tx_data : 8'h00);
				if (tx_sof) last_b2[k] <= acc_b2[k];
			end
		end
	end
endmodule // remote_line_rx

// File: verif/sonet_tx_overhead_insert_tb_top.sv
// Purpose: Self-checking bench for the transmit overhead block at STS-3 size.
// Assumes: The far-end model echoes the stream as the scrambled return.
// Notes: Scenarios wait two frames so the per-frame walker has run.
`timescale 1ns/1ps
`include "oh_map.svh"
module sonet_tx_overhead_insert_tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, tx_sof, scr_sof;
	logic overhead_program_mode_pin, sdh_mode_pin, cell_valid, cell_ready;
	logic rx_frame_loss, rx_signal_loss, rx_line_alarm_signal, rx_pointer_loss, rx_path_alarm_signal;
	logic rx_payload_label_mismatch, rx_path_unequipped, rx_cell_alignment_loss;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] dfx, cell_data, tx_data, scr_data;
	logic [3:0] rx_b3_errors;
	logic [6:0] rx_b2_errors;
	int fails, cmp_count, cyc, n;
	assign {rx_cell_alignment_loss, rx_path_unequipped, rx_payload_label_mismatch, rx_path_alarm_signal,
		rx_pointer_loss, rx_line_alarm_signal, rx_signal_loss, rx_frame_loss} = dfx;
	sonet_tx_overhead_insert #(.STS_N(3), .FIFO_DEPTH(4)) u_sonet_tx_overhead_insert (.*);
	remote_line_rx #(.STS_N(3)) u_remote_line_rx (.*);

	function automatic logic [7:0] ob(input int i);
		return u_remote_line_rx.fb[i];
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic frames(input int k);
		repeat (k) begin
			@(posedge pclk);
			while (tx_sof !== 1'h1) @(posedge pclk);
		end
	endtask
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// ==========
	// Scenarios
	task automatic t_regs;
		apb(1'h0, `REG_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'h0, 12'h0FC, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		chk(er, 32'h0000_0001);
		apb(1'h1, `REG_CTRL, 32'h0000_0007);
		frames(2);
		chk(ob(1086) & 8'h07, 8'h06);
		chk(ob(819), 8'h98);
		apb(1'h1, `REG_CTRL, 32'h0000_0000);
		$display("Test registers done");
	endtask
	task automatic t_norm;
		rx_b3_errors <= 4'h5;
		rx_b2_errors <= 7'h60;
		frames(2);
		chk(ob(810), 8'h62);
		chk({ob(811), ob(813), ob(814), ob(816)}, 32'h930A_FF00);
		chk(ob(819), 8'h50);
		chk(ob(2165) & 8'h7F, 8'h60);
		chk(ob(270), u_remote_line_rx.last_all);
		chk(ob(279), u_remote_line_rx.last_spe);
		for (int k = 0; k < 3; k++) begin
			chk(ob(1080 + k), u_remote_line_rx.last_b2[k]);
		end
		chk({ob(6), ob(7), ob(8)}, 32'h0001_0203);
		chk({ob(9), ob(1089)}, 16'h0000);
		$display("Test normal frame done");
	endtask
	task automatic t_fail;
		for (int i = 0; i < 5; i++) begin
			dfx <= 8'h01 << i;
			frames(2);
			chk(ob(1086), (i < 3) ? 8'h06 : 8'h00);
			chk(ob(819), (i < 3) ? 8'h90 : 8'h98);
		end
		dfx <= 8'h00;
		$display("Test remote failure done");
	endtask
	task automatic t_def;
		apb(1'h1, `REG_SOAK, 32'h0000_000A);
		apb(1'h1, `REG_CTRL, 32'h0000_0020);
		for (int i = 0; i < 3; i++) begin
			dfx <= 8'h20 << i;
			frames(2);
			chk(ob(819), (i == 0) ? 8'h54 : (i == 1) ? 8'h5C : 8'h58);
		end
		dfx <= 8'h00;
		apb(1'h1, `REG_CTRL, 32'h0000_0000);
		$display("Test remote defect done");
	endtask
	task automatic t_ais;
		apb(1'h1, `REG_CTRL, 32'h0000_0040);
		frames(2);
		chk(ob(1086), 8'hFF);
		apb(1'h1, `REG_CTRL, 32'h0000_0080);
		frames(2);
		chk(ob(810), 8'hFF);
		n = 0;
		cell_valid <= 1'h1;
		repeat (8) begin
			@(posedge pclk);
			if (cell_ready === 1'h1) n++;
			cell_data <= cell_data + 8'h01;
		end
		cell_valid <= 1'h0;
		chk(n, 4);
		apb(1'h1, `REG_CTRL, 32'h0000_0000);
		frames(2);
		chk({ob(810), ob(1086), 7'h00, cell_ready}, 24'h6200_01);
		$display("Test alarm signal done");
	endtask
	task automatic t_prog;
		overhead_program_mode_pin <= 1'h1;
		frames(1);
		apb(1'h1, `REG_RAM_ADDR, 32'h0000_0053);
		apb(1'h1, `REG_RAM_DATA, 32'h0000_0055);
		frames(2);
		chk(ob(549), 8'h55);
		overhead_program_mode_pin <= 1'h0;
		frames(2);
		chk(ob(549), 8'h13);
		$display("Test program mode done");
	endtask
	task automatic t_sdh;
		apb(1'h1, `REG_CTRL, 32'h0000_0008);
		frames(2);
		apb(1'h0, `REG_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0020);
		chk({ob(810), ob(811)}, 32'h0000_6A9B);
		chk({ob(6), ob(7), ob(8)}, 32'h0001_0000);
		$display("Test framing mode done");
	endtask

	initial begin
		pclk = 1'h0;
		forever #20 pclk = ~pclk;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{overhead_program_mode_pin, sdh_mode_pin, cell_valid, cell_data, dfx, rx_b3_errors, rx_b2_errors} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		t_regs();
		t_norm();
		t_fail();
		t_def();
		t_ais();
		t_prog();
		t_sdh();
		end_sim();
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			fails++;
			end_sim();
		end
	end
endmodule // sonet_tx_overhead_insert_tb_top
